/* File: core/wdbus_pkg.sv */
// Constants and encodings shared by the watchdog and bus control register bank.
// How it works
// - Decode registers at addresses 0x03, 0x04, 0x05.
// - Bit 6 low keeps watchdog active in stop.
// - Both stop-mode bits together switch watchdog off.
// - Bit 5 selects time-out or window watchdog.
// - Bit 4 restarts watchdog after bus wake.
// - Period field bits 2:0, bit 3 reserved, device-updatable.
// - Reset 0x14; restart reloads bits 6,3,2:0.
// - Reserved bits always read as zero.
// - Two mode bits select transceiver operating mode.
// - Bus mode resets zero; restart loads cause value.
// - Fail-safe forces bus mode 01, external wake load.
// - Bit 5 selects low or high peak threshold.
// - Peak bit writable only in init or normal.
// - Blocked peak write raises no failure or interrupt.
// - Peak register resets zero; restart keeps bit 5.
// - Global enable lets all status raise interrupt.
`default_nettype none
package wdbus_pkg;
	localparam logic [6:0] ADDR_WDOG = 7'h03;
	localparam logic [6:0] ADDR_BUS = 7'h04;
	localparam logic [6:0] ADDR_PEAK = 7'h05;
	localparam logic [7:0] WDOG_RESET = 8'h14;
	localparam logic [7:0] BUS_RESET = 8'h00;
	localparam logic [7:0] PEAK_RESET = 8'h00;
	localparam logic [2:0] WDOG_PERIOD_RESTART = 3'h4;
	localparam int WDOG_CHECKSUM_BIT = 7;
	localparam int WDOG_STOP_OFF_BIT = 6;
	localparam int WDOG_WINDOW_BIT = 5;
	localparam int WDOG_BUS_WAKE_BIT = 4;
	localparam int WDOG_RESERVED_BIT = 3;
	localparam int PEAK_SELECT_BIT = 5;
	typedef enum logic [1:0] {can_off, can_wake_capable, can_receive_only, can_normal} can_mode_e;
	localparam can_mode_e CAN_FAILSAFE = can_wake_capable;
endpackage
`default_nettype wire

/* File: core/wdog_cfg_if.sv */
// Signals between the register bank and its watchdog control register.
`default_nettype none
interface wdog_cfg_if;
	logic host_wr;
	logic [7:0] host_data;
	logic soft_reset;
	logic restart;
	logic dev_period_wr;
	logic [2:0] dev_period;
	logic dev_stop_off_wr;
	logic dev_stop_off;
	logic dev_bus_wake_wr;
	logic dev_bus_wake;
	logic [7:0] value;
	logic parity_err;
	modport regs (
		input host_wr, host_data, soft_reset, restart, dev_period_wr, dev_period,
		input dev_stop_off_wr, dev_stop_off, dev_bus_wake_wr, dev_bus_wake,
		output value, parity_err
	);
	modport ctrl (
		output host_wr, host_data, soft_reset, restart, dev_period_wr, dev_period,
		output dev_stop_off_wr, dev_stop_off, dev_bus_wake_wr, dev_bus_wake,
		input value, parity_err
	);
endinterface
`default_nettype wire

/* File: core/wdog_ctrl_reg.sv */
// Watchdog control register with checksum check and device-side updates.
`default_nettype none
module wdog_ctrl_reg (
	input wire logic mclk,
	input wire logic rst_n,
	wdog_cfg_if.regs cfg
);
	logic [7:0] value_reg;
	logic [7:0] value_next;
	logic parity_err_reg;
	logic parity_ok;

	assign parity_ok = ~^cfg.host_data;

	always_comb
	begin
		value_next = value_reg;
		if (cfg.host_wr && parity_ok)
		begin
			value_next = cfg.host_data;
		end
		// Device updates are applied after the host write so they win over it.
		if (cfg.dev_period_wr)
		begin
			value_next[2:0] = cfg.dev_period;
		end
		if (cfg.dev_stop_off_wr)
		begin
			value_next[wdbus_pkg::WDOG_STOP_OFF_BIT] = cfg.dev_stop_off;
		end
		if (cfg.dev_bus_wake_wr)
		begin
			value_next[wdbus_pkg::WDOG_BUS_WAKE_BIT] = cfg.dev_bus_wake;
		end
		value_next[wdbus_pkg::WDOG_RESERVED_BIT] = 1'b0;
		if (cfg.restart)
		begin
			// Restart outranks host and device updates, so bits 7, 5 and 4 keep their old value.
			value_next = value_reg;
			value_next[wdbus_pkg::WDOG_STOP_OFF_BIT] = 1'b0;
			value_next[wdbus_pkg::WDOG_RESERVED_BIT] = 1'b0;
			value_next[2:0] = wdbus_pkg::WDOG_PERIOD_RESTART;
		end
		if (cfg.soft_reset)
		begin
			value_next = wdbus_pkg::WDOG_RESET;
		end
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			value_reg <= wdbus_pkg::WDOG_RESET;
		else
			value_reg <= value_next;
	end

	// The flag stays up until a correctly checksummed write is accepted or a soft reset clears it.
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			parity_err_reg <= 1'b0;
		else if (cfg.soft_reset)
			parity_err_reg <= 1'b0;
		else if (cfg.host_wr)
			parity_err_reg <= ~parity_ok;
	end

	assign cfg.value = value_reg;
	assign cfg.parity_err = parity_err_reg;

	property p_odd_write_kept;
		@(posedge mclk) disable iff (!rst_n)
		(cfg.host_wr && !parity_ok && !cfg.soft_reset && !cfg.restart && !cfg.dev_period_wr
			&& !cfg.dev_stop_off_wr && !cfg.dev_bus_wake_wr) |=> $stable(value_reg);
	endproperty
	a_odd_write_kept: assert property (p_odd_write_kept) else $error("odd write changed wdog");

	property p_restart_reload;
		@(posedge mclk) disable iff (!rst_n)
		(cfg.restart && !cfg.soft_reset) |=> (value_reg[2:0] == wdbus_pkg::WDOG_PERIOD_RESTART)
			&& !value_reg[wdbus_pkg::WDOG_STOP_OFF_BIT]
			&& !value_reg[wdbus_pkg::WDOG_RESERVED_BIT]
			&& (value_reg[5:4] == $past(value_reg[5:4]));
	endproperty
	a_restart_reload: assert property (p_restart_reload) else $error("restart reload wrong");
endmodule
`default_nettype wire

/* File: core/sbc_ctrl_regs.sv */
// Register bank for watchdog setup, transceiver mode and peak-current threshold.
`default_nettype none
module sbc_ctrl_regs (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic soft_reset,
	input wire logic restart_entry,
	input wire logic failsafe_entry,
	input wire logic [1:0] restart_can,
	input wire logic mode_init,
	input wire logic mode_normal,
	input wire logic mode_stop,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [6:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata,
	input wire logic dev_period_wr,
	input wire logic [2:0] dev_period,
	input wire logic dev_stop_off_wr,
	input wire logic dev_stop_off,
	input wire logic dev_bus_wake_wr,
	input wire logic dev_bus_wake,
	input wire logic dev_can_wr,
	input wire logic [1:0] dev_can,
	input wire logic stop_mode_wdog_off_hi,
	input wire logic int_global,
	input wire logic status_pending,
	input wire logic wake_pending,
	output logic window_type_select,
	output logic wdog_restart_on_bus_wake,
	output logic [2:0] wdog_period_field,
	output logic stop_mode_wdog_off_lo,
	output logic wdog_off_in_stop,
	output logic wdog_cfg_invalid,
	output logic [1:0] can_mode,
	output logic peak_threshold_select,
	output logic external_wake_failsafe_load,
	output logic int_req
);
	wdog_cfg_if wdog_if ();

	logic [1:0] can_reg;
	logic peak_reg;
	logic [7:0] rdata_reg;
	logic off_reg;
	logic ext_load_reg;
	logic int_reg;
	logic wr_wdog;
	logic wr_bus;
	logic wr_peak;
	logic peak_writable;

	assign wr_wdog = wr_en && (addr == wdbus_pkg::ADDR_WDOG);
	assign wr_bus = wr_en && (addr == wdbus_pkg::ADDR_BUS);
	assign wr_peak = wr_en && (addr == wdbus_pkg::ADDR_PEAK);
	// Stop is tested on its own as well, so a mode overlap during a transition still blocks writes.
	assign peak_writable = (mode_init || mode_normal) && !mode_stop;

	assign wdog_if.host_wr = wr_wdog;
	assign wdog_if.host_data = wdata;
	assign wdog_if.soft_reset = soft_reset;
	assign wdog_if.restart = restart_entry;
	assign wdog_if.dev_period_wr = dev_period_wr;
	assign wdog_if.dev_period = dev_period;
	assign wdog_if.dev_stop_off_wr = dev_stop_off_wr;
	assign wdog_if.dev_stop_off = dev_stop_off;
	assign wdog_if.dev_bus_wake_wr = dev_bus_wake_wr;
	assign wdog_if.dev_bus_wake = dev_bus_wake;

	wdog_ctrl_reg wdog_ctrl_reg_inst (
		.mclk(mclk),
		.rst_n(rst_n),
		.cfg(wdog_if.regs)
	);

	// Transceiver mode: soft reset, then restart, then fail-safe, then device, then host.
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			can_reg <= wdbus_pkg::BUS_RESET[1:0];
		else if (soft_reset)
			can_reg <= wdbus_pkg::BUS_RESET[1:0];
		else if (restart_entry)
			can_reg <= restart_can;
		else if (failsafe_entry)
			can_reg <= wdbus_pkg::CAN_FAILSAFE;
		else if (dev_can_wr)
			can_reg <= dev_can;
		else if (wr_bus)
			can_reg <= wdata[1:0];
	end

	// A stop-mode write is dropped silently: no failure flag and no interrupt follow it.
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			peak_reg <= wdbus_pkg::PEAK_RESET[wdbus_pkg::PEAK_SELECT_BIT];
		else if (soft_reset)
			peak_reg <= wdbus_pkg::PEAK_RESET[wdbus_pkg::PEAK_SELECT_BIT];
		else if (wr_peak && peak_writable && !restart_entry)
			peak_reg <= wdata[wdbus_pkg::PEAK_SELECT_BIT];
	end

	// The external wake register lives elsewhere; it is told to load its fail-safe value.
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			ext_load_reg <= 1'b0;
		else
			ext_load_reg <= failsafe_entry && !soft_reset && !restart_entry;
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			off_reg <= 1'b0;
		else
			off_reg <= wdog_if.value[wdbus_pkg::WDOG_STOP_OFF_BIT] && stop_mode_wdog_off_hi;
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			int_reg <= 1'b0;
		else
			int_reg <= wake_pending || (int_global && status_pending);
	end

	// Readback; unmapped addresses and every reserved bit read as zero.
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			rdata_reg <= 8'h00;
		else if (rd_en)
		begin
			unique case (addr)
				wdbus_pkg::ADDR_WDOG: rdata_reg <= wdog_if.value;
				wdbus_pkg::ADDR_BUS: rdata_reg <= {6'h00, can_reg};
				wdbus_pkg::ADDR_PEAK: rdata_reg <= {2'h0, peak_reg, 5'h00};
				default: rdata_reg <= 8'h00;
			endcase
		end
	end

	assign rdata = rdata_reg;
	assign window_type_select = wdog_if.value[wdbus_pkg::WDOG_WINDOW_BIT];
	assign wdog_restart_on_bus_wake = wdog_if.value[wdbus_pkg::WDOG_BUS_WAKE_BIT];
	assign wdog_period_field = wdog_if.value[2:0];
	assign stop_mode_wdog_off_lo = wdog_if.value[wdbus_pkg::WDOG_STOP_OFF_BIT];
	assign wdog_off_in_stop = off_reg;
	assign wdog_cfg_invalid = wdog_if.parity_err;
	assign can_mode = can_reg;
	assign peak_threshold_select = peak_reg;
	assign external_wake_failsafe_load = ext_load_reg;
	assign int_req = int_reg;

	property p_soft_reset_values;
		@(posedge mclk) disable iff (!rst_n)
		soft_reset |=> (wdog_if.value == wdbus_pkg::WDOG_RESET)
			&& (can_reg == wdbus_pkg::BUS_RESET[1:0]) && !peak_reg;
	endproperty
	a_soft_reset_values: assert property (p_soft_reset_values) else $error("soft reset values");

	property p_restart_can;
		@(posedge mclk) disable iff (!rst_n)
		(restart_entry && !soft_reset) |=> (can_reg == $past(restart_can)) && $stable(peak_reg);
	endproperty
	a_restart_can: assert property (p_restart_can) else $error("restart bus values wrong");

	property p_failsafe;
		@(posedge mclk) disable iff (!rst_n)
		(failsafe_entry && !soft_reset && !restart_entry)
			|=> ((can_reg == wdbus_pkg::CAN_FAILSAFE) && external_wake_failsafe_load)
			##1 (!external_wake_failsafe_load || $past(failsafe_entry));
	endproperty
	a_failsafe: assert property (p_failsafe) else $error("fail-safe load wrong");

	property p_peak_stop_kept;
		@(posedge mclk) disable iff (!rst_n)
		(wr_peak && !mode_init && !mode_normal && !soft_reset) |=> $stable(peak_reg);
	endproperty
	a_peak_stop_kept: assert property (p_peak_stop_kept) else $error("peak changed in stop");

	property p_peak_written;
		@(posedge mclk) disable iff (!rst_n)
		(wr_peak && mode_normal && !soft_reset && !restart_entry)
			|=> peak_reg == $past(wdata[wdbus_pkg::PEAK_SELECT_BIT]);
	endproperty
	a_peak_written: assert property (p_peak_written) else $error("peak write lost");

	property p_device_wins;
		@(posedge mclk) disable iff (!rst_n)
		(dev_can_wr && wr_bus && !soft_reset && !restart_entry && !failsafe_entry)
			|=> can_reg == $past(dev_can);
	endproperty
	a_device_wins: assert property (p_device_wins) else $error("host beat device");

	property p_bus_written;
		@(posedge mclk) disable iff (!rst_n)
		(wr_bus && !dev_can_wr && !soft_reset && !restart_entry && !failsafe_entry)
			|=> can_reg == $past(wdata[1:0]);
	endproperty
	a_bus_written: assert property (p_bus_written) else $error("bus mode write lost");

	property p_reserved_zero;
		@(posedge mclk) disable iff (!rst_n)
		(rd_en && addr == wdbus_pkg::ADDR_PEAK) ##1 1'b1 |-> (rdata[7:6] == 2'h0)
			&& (rdata[4:0] == 5'h00);
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

	property p_stop_off;
		@(posedge mclk) disable iff (!rst_n)
		(stop_mode_wdog_off_lo && stop_mode_wdog_off_hi) |=> wdog_off_in_stop;
	endproperty
	a_stop_off: assert property (p_stop_off) else $error("stop deactivation missed");

	property p_int_gate;
		@(posedge mclk) disable iff (!rst_n)
		(status_pending && !wake_pending) |=> int_req == $past(int_global);
	endproperty
	a_int_gate: assert property (p_int_gate) else $error("interrupt gating wrong");
endmodule
`default_nettype wire

/* File: test/host_model.sv */
// Host model that issues register reads and writes to the control bank.
`default_nettype none
module host_model (
	input wire logic mclk,
	output logic wr_en,
	output logic rd_en,
	output logic [6:0] addr,
	output logic [7:0] wdata,
	input wire logic [7:0] rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		wr_en = 1'b0;
		rd_en = 1'b0;
		addr = 7'h00;
		wdata = 8'h00;
	end
	task write(input logic [6:0] a, input logic [7:0] d);
		@(posedge mclk);
		wr_en <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge mclk);
		wr_en <= 1'b0;
		#1;
	endtask
	// The checksum bit is chosen so that the whole byte has even parity.
	task write_wdog(input logic [6:0] d);
		write(wdbus_pkg::ADDR_WDOG, {^d, d});
	endtask
	task read(input logic [6:0] a, output logic [7:0] d);
		@(posedge mclk);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge mclk);
		rd_en <= 1'b0;
		#1;
		d = rdata;
	endtask
endmodule
`default_nettype wire

/* File: test/sbc_ctrl_regs_bench.sv */
// Self-checking bench for the watchdog, transceiver mode and peak threshold registers.
`default_nettype none
module sbc_ctrl_regs_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk, rst_n, wr_en, rd_en, mode_init, mode_normal, mode_stop;
	logic [2:0] ev;
	logic [1:0] restart_can, dev_can, can_mode;
	logic [6:0] addr;
	logic [7:0] wdata, rdata, d;
	logic dev_period_wr, dev_stop_off_wr, dev_stop_off, dev_bus_wake_wr, dev_bus_wake, dev_can_wr;
	logic [2:0] dev_period, wdog_period_field;
	logic off_hi, int_global, status_pending, wake_pending, window_type_select;
	logic wdog_restart_on_bus_wake, stop_mode_wdog_off_lo, wdog_off_in_stop, wdog_cfg_invalid;
	logic peak_threshold_select, external_wake_failsafe_load, int_req;
	int fails, n_compared, cycles;
	sbc_ctrl_regs sbc_ctrl_regs_inst (.mclk(mclk), .rst_n(rst_n), .soft_reset(ev[0]),
		.restart_entry(ev[1]), .failsafe_entry(ev[2]), .restart_can(restart_can),
		.mode_init(mode_init), .mode_normal(mode_normal), .mode_stop(mode_stop),
		.wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata), .rdata(rdata),
		.dev_period_wr(dev_period_wr), .dev_period(dev_period), .dev_stop_off_wr(dev_stop_off_wr),
		.dev_stop_off(dev_stop_off), .dev_bus_wake_wr(dev_bus_wake_wr),
		.dev_bus_wake(dev_bus_wake), .dev_can_wr(dev_can_wr), .dev_can(dev_can),
		.stop_mode_wdog_off_hi(off_hi), .int_global(int_global),
		.status_pending(status_pending), .wake_pending(wake_pending),
		.window_type_select(window_type_select),
		.wdog_restart_on_bus_wake(wdog_restart_on_bus_wake),
		.wdog_period_field(wdog_period_field), .stop_mode_wdog_off_lo(stop_mode_wdog_off_lo),
		.wdog_off_in_stop(wdog_off_in_stop), .wdog_cfg_invalid(wdog_cfg_invalid),
		.can_mode(can_mode), .peak_threshold_select(peak_threshold_select),
		.external_wake_failsafe_load(external_wake_failsafe_load), .int_req(int_req));
	host_model host_model_inst (.mclk(mclk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
		.wdata(wdata), .rdata(rdata));
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	task close_out();
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			fails++;
			$display("unexpected at %0t: got %h, want %h", $time, got, exp);
		end
	endtask
	task rchk(input logic [6:0] a, input logic [7:0] exp);
		host_model_inst.read(a, d);
		chk(d, exp);
	endtask
	// Event pulses last one cycle; outputs are looked at just after the edge that takes them.
	task fire(input int i);
		@(posedge mclk);
		ev[i] <= 1'b1;
		@(posedge mclk);
		ev[i] <= 1'b0;
		#1;
	endtask
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			fails++;
			close_out();
		end
	end
	initial
	begin
		{rst_n, ev, restart_can, dev_can, dev_period} = '0;
		{dev_period_wr, dev_stop_off_wr, dev_stop_off, dev_bus_wake_wr, dev_bus_wake} = '0;
		{dev_can_wr, mode_init, mode_stop, int_global, status_pending, wake_pending} = '0;
		{mode_normal, off_hi} = 2'b11;
		{fails, n_compared, cycles} = '0;
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		rchk(wdbus_pkg::ADDR_WDOG, 8'h14);
		rchk(wdbus_pkg::ADDR_BUS, 8'h00);
		rchk(wdbus_pkg::ADDR_PEAK, 8'h00);
		rchk(7'h06, 8'h00);
		host_model_inst.write_wdog(7'h6b);
		rchk(wdbus_pkg::ADDR_WDOG, 8'he3);
		chk(window_type_select, 8'h01);
		chk(wdog_restart_on_bus_wake, 8'h00);
		chk(wdog_period_field, 8'h03);
		chk(stop_mode_wdog_off_lo, 8'h01);
		chk(wdog_off_in_stop, 8'h01);
		@(posedge mclk);
		off_hi <= 1'b0;
		repeat (2) @(posedge mclk);
		#1;
		chk(wdog_off_in_stop, 8'h00);
		host_model_inst.write(wdbus_pkg::ADDR_WDOG, 8'h01);
		chk(wdog_cfg_invalid, 8'h01);
		rchk(wdbus_pkg::ADDR_WDOG, 8'he3);
		for (int i = 0; i < 4; i++)
		begin
			host_model_inst.write(wdbus_pkg::ADDR_BUS, {6'h3f, i[1:0]});
			chk(can_mode, {6'h00, i[1:0]});
			rchk(wdbus_pkg::ADDR_BUS, {6'h00, i[1:0]});
		end
		fork
			host_model_inst.write(wdbus_pkg::ADDR_BUS, 8'h03);
			begin
				@(posedge mclk);
				{dev_can_wr, dev_period_wr, dev_stop_off_wr, dev_bus_wake_wr} <= 4'hf;
				{dev_can, dev_period, dev_stop_off, dev_bus_wake} <= {2'h0, 3'h6, 2'h3};
				@(posedge mclk);
				{dev_can_wr, dev_period_wr, dev_stop_off_wr, dev_bus_wake_wr} <= 4'h0;
			end
		join
		chk(can_mode, 8'h00);
		rchk(wdbus_pkg::ADDR_WDOG, 8'hf6);
		host_model_inst.write(wdbus_pkg::ADDR_PEAK, 8'hff);
		rchk(wdbus_pkg::ADDR_PEAK, 8'h20);
		chk(peak_threshold_select, 8'h01);
		restart_can <= 2'h2;
		fire(1);
		chk(can_mode, 8'h02);
		rchk(wdbus_pkg::ADDR_WDOG, 8'hb4);
		rchk(wdbus_pkg::ADDR_PEAK, 8'h20);
		{mode_normal, mode_stop, int_global} <= 3'b011;
		host_model_inst.write(wdbus_pkg::ADDR_PEAK, 8'h00);
		rchk(wdbus_pkg::ADDR_PEAK, 8'h20);
		chk(int_req, 8'h00);
		{mode_stop, mode_init} <= 2'b01;
		host_model_inst.write(wdbus_pkg::ADDR_PEAK, 8'h00);
		rchk(wdbus_pkg::ADDR_PEAK, 8'h00);
		fire(2);
		chk({can_mode, external_wake_failsafe_load}, 8'h03);
		@(posedge mclk);
		#1;
		chk(external_wake_failsafe_load, 8'h00);
		for (int i = 0; i < 5; i++)
		begin
			@(posedge mclk);
			{wake_pending, int_global, status_pending} <= i[2:0];
			repeat (2) @(posedge mclk);
			#1;
			chk(int_req, {7'h00, i >= 3});
		end
		fire(0);
		rchk(wdbus_pkg::ADDR_WDOG, 8'h14);
		rchk(wdbus_pkg::ADDR_BUS, 8'h00);
		rchk(wdbus_pkg::ADDR_PEAK, 8'h00);
		close_out();
	end
endmodule
`default_nettype wire
